/* File: pkg/fcs_pkg.sv */
// fcs_pkg: constants, command codes and carriers for the flash command sequencer
// assumes one clock domain shared with the flash control logic
package fcs_pkg;
  localparam int         ADDR_W             = 20;
  localparam int         DATA_W             = 16;
  localparam logic [7:0] CODE_READ_ARRAY    = 8'hff;
  localparam logic [7:0] CODE_READ_STATUS   = 8'h70;
  localparam logic [7:0] CODE_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0] CODE_PROGRAM       = 8'h40;
  localparam logic [7:0] CODE_ERASE         = 8'h20;
  localparam logic [7:0] CODE_LOCK_PROGRAM  = 8'h77;
  localparam logic [7:0] CODE_READ_LOCK     = 8'h71;
  localparam logic [7:0] CODE_CONFIRM       = 8'hd0;
  localparam logic [7:0] UPPER_IGNORED      = 8'h00;
  localparam int         STATUS_READY_POS   = 7;
  localparam int         STATUS_ERASE_POS   = 5;
  localparam int         STATUS_PROG_POS    = 4;
  localparam logic [1:0] ERASE_TRIES        = 2'h3;
  localparam logic [1:0] POLL_SETTLE        = 2'h2;
  localparam logic [1:0] LP_RUN             = 2'h0;
  localparam logic [1:0] LP_REWRITE_OFF     = 2'h1;
  localparam logic [1:0] LP_DMA_OFF         = 2'h2;
  localparam logic [1:0] LP_STOP            = 2'h3;

  typedef enum logic [2:0] {
    OP_READ         = 3'h0,
    OP_READ_ARRAY   = 3'h1,
    OP_READ_STATUS  = 3'h2,
    OP_CLEAR_STATUS = 3'h3,
    OP_PROGRAM      = 3'h4,
    OP_ERASE        = 3'h5,
    OP_LOCK_PROGRAM = 3'h6,
    OP_READ_LOCK    = 3'h7
  } fcs_op_t;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_FIRST   = 7'h02,
    ST_SECOND  = 7'h04,
    ST_POLL    = 7'h08,
    ST_READ    = 7'h10,
    ST_CAPTURE = 7'h20,
    ST_DONE    = 7'h40
  } fcs_state_t;

  typedef struct packed {
    fcs_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcs_cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              refused;
    logic              prog_err;
    logic              erase_err;
  } fcs_resp_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } fcs_bus_t;
endpackage : fcs_pkg

/* File: logic/fcs_sequencer.sv */
// fcs_sequencer: drives flash rewrite command sequences on behalf of a user port
// assumes flash control flags and read data come from logic on clk_sys
//
// What this block does
// - 16-bit words, even addresses, upper byte ignored
// - no read status in flash-executed mode
// - program is 40h then data, same address
// - flash mode never programs or erases control program block
// - erase is 20h then D0h at block top
// - erase error: clear and retry three times
// - lock program is 77h then D0h, same address
// - read lock 71h/D0h, read after ready
// - stop: rewrite off, DMA off, then stop
// - no flash operations while main clock stopped
`timescale 1ns/10ps
module fcs_sequencer (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          cmd_valid,
  input  wire fcs_pkg::fcs_cmd_t             cmd,
  output logic                               cmd_ready,
  output logic                               resp_valid,
  output fcs_pkg::fcs_resp_t                 resp,
  output fcs_pkg::fcs_bus_t                  bus,
  input  wire logic [fcs_pkg::DATA_W-1:0]    dev_rdata,
  input  wire logic                          sequencer_ready_flag,
  input  wire logic                          program_error_flag,
  input  wire logic                          erase_error_flag,
  input  wire logic                          lock_status_flag,
  input  wire logic                          flash_executed_rewrite_mode,
  input  wire logic                          main_clock_stop_bit,
  input  wire logic [fcs_pkg::ADDR_W-1:0]    prot_lo,
  input  wire logic [fcs_pkg::ADDR_W-1:0]    prot_hi,
  input  wire logic                          rewrite_en_req,
  input  wire logic                          wait_req,
  input  wire logic                          stop_req,
  output logic                               cpu_rewrite_enable,
  output logic                               dma_disable,
  output logic                               stop_mode_bit
);
  fcs_pkg::fcs_state_t state_ff,   nxt_state;
  fcs_pkg::fcs_cmd_t   cmd_ff,     nxt_cmd;
  fcs_pkg::fcs_resp_t  resp_ff,    nxt_resp;
  fcs_pkg::fcs_bus_t   bus_ff,     nxt_bus;
  logic [7:0]          code_ff,    nxt_code;
  logic [1:0]          tries_ff,   nxt_tries;
  logic [1:0]          settle_ff,  nxt_settle;
  logic [1:0]          lp_ff,      nxt_lp;
  logic                rwen_ff,    nxt_rwen;
  logic                refuse_w;

  function automatic logic [7:0] code_of(input fcs_pkg::fcs_op_t op);
    unique case (op)
      fcs_pkg::OP_READ_ARRAY:   code_of = fcs_pkg::CODE_READ_ARRAY;
      fcs_pkg::OP_READ_STATUS:  code_of = fcs_pkg::CODE_READ_STATUS;
      fcs_pkg::OP_CLEAR_STATUS: code_of = fcs_pkg::CODE_CLEAR_STATUS;
      fcs_pkg::OP_PROGRAM:      code_of = fcs_pkg::CODE_PROGRAM;
      fcs_pkg::OP_ERASE:        code_of = fcs_pkg::CODE_ERASE;
      fcs_pkg::OP_LOCK_PROGRAM: code_of = fcs_pkg::CODE_LOCK_PROGRAM;
      fcs_pkg::OP_READ_LOCK:    code_of = fcs_pkg::CODE_READ_LOCK;
      default:                  code_of = fcs_pkg::CODE_READ_ARRAY;
    endcase
  endfunction : code_of

  // operations that run the automatic sequencer and take two writes
  function automatic logic is_flash_op(input fcs_pkg::fcs_op_t op);
    is_flash_op = (op == fcs_pkg::OP_PROGRAM) || (op == fcs_pkg::OP_ERASE) ||
                  (op == fcs_pkg::OP_LOCK_PROGRAM) || (op == fcs_pkg::OP_READ_LOCK);
  endfunction : is_flash_op

  function automatic logic in_prot(input logic [fcs_pkg::ADDR_W-1:0] a);
    in_prot = (a >= prot_lo) && (a <= prot_hi);
  endfunction : in_prot

  // refusal decided at acceptance
  always_comb begin
    refuse_w = 1'b0;
    if (cmd.op != fcs_pkg::OP_READ && !rwen_ff)
      refuse_w = 1'b1;
    if (is_flash_op(cmd.op) && main_clock_stop_bit)
      refuse_w = 1'b1;
    if (cmd.op == fcs_pkg::OP_READ_STATUS && flash_executed_rewrite_mode)
      refuse_w = 1'b1;
    if ((cmd.op == fcs_pkg::OP_PROGRAM || cmd.op == fcs_pkg::OP_ERASE) &&
        flash_executed_rewrite_mode && in_prot(cmd.addr))
      refuse_w = 1'b1;
  end

  assign cmd_ready  = (state_ff == fcs_pkg::ST_IDLE) && (lp_ff == fcs_pkg::LP_RUN) && !stop_req && !wait_req;
  assign resp_valid = (state_ff == fcs_pkg::ST_DONE);
  assign resp       = resp_ff;
  assign bus        = bus_ff;

  // command sequencing
  always_comb begin
    nxt_state  = state_ff;
    nxt_cmd    = cmd_ff;
    nxt_code   = code_ff;
    nxt_tries  = tries_ff;
    nxt_settle = settle_ff;
    nxt_resp   = resp_ff;
    unique case (state_ff)
      fcs_pkg::ST_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          nxt_cmd         = cmd;
          nxt_cmd.addr[0] = 1'b0;
          nxt_code        = code_of(cmd.op);
          nxt_tries       = 2'h0;
          nxt_resp        = '0;
          if (refuse_w) begin
            nxt_resp.refused = 1'b1;
            nxt_state        = fcs_pkg::ST_DONE;
          end else if (cmd.op == fcs_pkg::OP_READ) begin
            nxt_state = fcs_pkg::ST_READ;
          end else begin
            nxt_state = fcs_pkg::ST_FIRST;
          end
        end
      end
      fcs_pkg::ST_FIRST: begin
        if (code_ff == fcs_pkg::CODE_CLEAR_STATUS && cmd_ff.op == fcs_pkg::OP_ERASE) begin
          nxt_code = fcs_pkg::CODE_ERASE;
        end else if (is_flash_op(cmd_ff.op)) begin
          nxt_state = fcs_pkg::ST_SECOND;
        end else if (cmd_ff.op == fcs_pkg::OP_READ_STATUS) begin
          nxt_state = fcs_pkg::ST_READ;
        end else begin
          nxt_state = fcs_pkg::ST_DONE;
        end
      end
      fcs_pkg::ST_SECOND: begin
        nxt_settle = 2'h0;
        nxt_state  = fcs_pkg::ST_POLL;
      end
      fcs_pkg::ST_POLL: begin
        if (settle_ff != fcs_pkg::POLL_SETTLE) begin
          nxt_settle = settle_ff + 2'h1;
        end else if (sequencer_ready_flag) begin
          if (cmd_ff.op == fcs_pkg::OP_ERASE && erase_error_flag && tries_ff != fcs_pkg::ERASE_TRIES) begin
            nxt_tries = tries_ff + 2'h1;
            nxt_code  = fcs_pkg::CODE_CLEAR_STATUS;
            nxt_state = fcs_pkg::ST_FIRST;
          end else begin
            nxt_resp.prog_err  = program_error_flag;
            nxt_resp.erase_err = erase_error_flag;
            nxt_resp.data      = '0;
            nxt_resp.data[fcs_pkg::STATUS_READY_POS] = sequencer_ready_flag;
            nxt_resp.data[fcs_pkg::STATUS_ERASE_POS] = erase_error_flag;
            nxt_resp.data[fcs_pkg::STATUS_PROG_POS]  = program_error_flag;
            if (cmd_ff.op == fcs_pkg::OP_READ_LOCK)
              nxt_resp.data = {{(fcs_pkg::DATA_W-1){1'b0}}, lock_status_flag};
            nxt_state = fcs_pkg::ST_DONE;
          end
        end
      end
      fcs_pkg::ST_READ: begin
        nxt_state = fcs_pkg::ST_CAPTURE;
      end
      fcs_pkg::ST_CAPTURE: begin
        if (cmd_ff.op == fcs_pkg::OP_READ_STATUS)
          nxt_resp.data = {fcs_pkg::UPPER_IGNORED, dev_rdata[7:0]};
        else
          nxt_resp.data = dev_rdata;
        nxt_state = fcs_pkg::ST_DONE;
      end
      fcs_pkg::ST_DONE: begin
        nxt_state = fcs_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = fcs_pkg::ST_IDLE;
      end
    endcase
    nxt_bus       = '0;
    nxt_bus.addr  = nxt_cmd.addr;
    nxt_bus.we    = (nxt_state == fcs_pkg::ST_FIRST) || (nxt_state == fcs_pkg::ST_SECOND);
    nxt_bus.re    = (nxt_state == fcs_pkg::ST_READ);
    nxt_bus.wdata = {fcs_pkg::UPPER_IGNORED, nxt_code};
    if (nxt_state == fcs_pkg::ST_SECOND) begin
      if (nxt_cmd.op == fcs_pkg::OP_PROGRAM)
        nxt_bus.wdata = nxt_cmd.data;
      else
        nxt_bus.wdata = {fcs_pkg::UPPER_IGNORED, fcs_pkg::CODE_CONFIRM};
    end
  end

  // low power entry ordering
  always_comb begin
    nxt_lp = fcs_pkg::LP_RUN;
    if (stop_req && (state_ff == fcs_pkg::ST_IDLE || lp_ff != fcs_pkg::LP_RUN)) begin
      unique case (lp_ff)
        fcs_pkg::LP_RUN:         nxt_lp = fcs_pkg::LP_REWRITE_OFF;
        fcs_pkg::LP_REWRITE_OFF: nxt_lp = fcs_pkg::LP_DMA_OFF;
        default:                 nxt_lp = fcs_pkg::LP_STOP;
      endcase
    end
    nxt_rwen = rewrite_en_req && !wait_req && !stop_req && (lp_ff == fcs_pkg::LP_RUN);
  end

  assign cpu_rewrite_enable = rwen_ff;
  assign dma_disable        = (lp_ff == fcs_pkg::LP_DMA_OFF) || (lp_ff == fcs_pkg::LP_STOP);
  assign stop_mode_bit      = (lp_ff == fcs_pkg::LP_STOP);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff  <= fcs_pkg::ST_IDLE;
      cmd_ff    <= '0;
      resp_ff   <= '0;
      bus_ff    <= '0;
      code_ff   <= 8'h00;
      tries_ff  <= 2'h0;
      settle_ff <= 2'h0;
      lp_ff     <= fcs_pkg::LP_RUN;
      rwen_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cmd_ff    <= nxt_cmd;
      resp_ff   <= nxt_resp;
      bus_ff    <= nxt_bus;
      code_ff   <= nxt_code;
      tries_ff  <= nxt_tries;
      settle_ff <= nxt_settle;
      lp_ff     <= nxt_lp;
      rwen_ff   <= nxt_rwen;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_even_address: assert property ((bus.we || bus.re) |-> !bus.addr[0])
    else $error("bus access to odd address");
  chk_upper_byte_zero: assert property (
    (state_ff == fcs_pkg::ST_FIRST) |-> bus.we && bus.wdata[15:8] == 8'h00)
    else $error("command word upper byte not zero");
  chk_no_status_flashexec: assert property (
    (cmd_valid && cmd_ready && cmd.op == fcs_pkg::OP_READ_STATUS && flash_executed_rewrite_mode)
    |=> resp_valid && resp.refused)
    else $error("read status issued in flash executed mode");
  chk_prog_same_addr: assert property (
    (state_ff == fcs_pkg::ST_SECOND && cmd_ff.op == fcs_pkg::OP_PROGRAM)
    |-> bus.we && $past(bus.we) && bus.addr == $past(bus.addr) && bus.wdata == cmd_ff.data)
    else $error("program second write mismatch");
  chk_erase_confirm: assert property (
    (state_ff == fcs_pkg::ST_SECOND && cmd_ff.op == fcs_pkg::OP_ERASE)
    |-> bus.wdata[7:0] == 8'hd0 && $past(bus.wdata[7:0]) == 8'h20)
    else $error("erase confirm sequence wrong");
  chk_lock_confirm: assert property (
    (state_ff == fcs_pkg::ST_SECOND && cmd_ff.op == fcs_pkg::OP_LOCK_PROGRAM)
    |-> bus.wdata[7:0] == 8'hd0 && $past(bus.wdata[7:0]) == 8'h77 && bus.addr == $past(bus.addr))
    else $error("lock program sequence wrong");
  chk_lock_after_ready: assert property (
    (resp_valid && cmd_ff.op == fcs_pkg::OP_READ_LOCK && !resp.refused) |-> $past(sequencer_ready_flag))
    else $error("lock status taken before ready");
  chk_erase_retry_bound: assert property (
    (state_ff == fcs_pkg::ST_FIRST && code_ff == fcs_pkg::CODE_CLEAR_STATUS && cmd_ff.op == fcs_pkg::OP_ERASE)
    |-> tries_ff != 2'h0 && tries_ff == $past(tries_ff) + 2'h1)
    else $error("erase retried too often");
  chk_stop_order: assert property (
    $rose(stop_mode_bit) |-> !cpu_rewrite_enable && $past(dma_disable) && !$past(cpu_rewrite_enable, 2))
    else $error("stop entered before rewrite and dma off");
  chk_no_cmd_clkstop: assert property (
    (cmd_valid && cmd_ready && is_flash_op(cmd.op) && main_clock_stop_bit) |=> resp_valid && resp.refused)
    else $error("flash operation accepted with main clock stopped");
  chk_prot_block: assert property (
    (state_ff == fcs_pkg::ST_FIRST && $past(state_ff) == fcs_pkg::ST_IDLE && flash_executed_rewrite_mode
     && (cmd_ff.op == fcs_pkg::OP_PROGRAM || cmd_ff.op == fcs_pkg::OP_ERASE)) |-> !in_prot(cmd_ff.addr))
    else $error("control program block targeted");

  cov_program_done: cover property (resp_valid && cmd_ff.op == fcs_pkg::OP_PROGRAM && !resp.refused);
  cov_erase_retry: cover property (state_ff == fcs_pkg::ST_FIRST && code_ff == fcs_pkg::CODE_CLEAR_STATUS &&
    tries_ff != 2'h0);
  cov_read_status: cover property (resp_valid && cmd_ff.op == fcs_pkg::OP_READ_STATUS && !resp.refused);
  cov_stop_entry: cover property ($rose(stop_mode_bit));
endmodule : fcs_sequencer

/* File: tb/fcs_flash_model.sv */
// fcs_flash_model: flash array, lock bits and command interpreter facing the sequencer
// assumes bus pulses, flags and read data all live on clk_sys
`timescale 1ns/10ps
module fcs_flash_model (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire fcs_pkg::fcs_bus_t bus,
  input  wire logic              lock_disable_bit,
  input  wire logic [7:0]        busy_len,
  output logic [15:0]            dev_rdata,
  output logic                   sequencer_ready_flag,
  output logic                   program_error_flag,
  output logic                   erase_error_flag,
  output logic                   lock_status_flag
);
  logic [15:0] mem_ff [64];
  logic [15:0] rd_ff;
  logic [7:0]  first_ff, busy_ff, code;
  logic [3:0]  lock_ff;
  logic [1:0]  blk;
  logic        stat_ff, hold_ff, pe_pend_ff, ee_pend_ff, open_ok;
  assign code = bus.wdata[7:0];  // upper byte ignored
  assign blk = bus.addr[6:5];
  assign open_ok = lock_disable_bit | lock_ff[blk];
  assign sequencer_ready_flag = busy_ff == 8'h00;
  // read data only holds in the cycle after the read
  assign dev_rdata = hold_ff ? rd_ff : ~rd_ff;
  always_ff @(posedge clk_sys) begin
    hold_ff <= bus.re;
    if (busy_ff != 8'h00) busy_ff <= busy_ff - 8'h01;
    if (busy_ff == 8'h01) begin  // outcome at finish
      program_error_flag <= program_error_flag | pe_pend_ff;
      erase_error_flag   <= erase_error_flag | ee_pend_ff;
    end
    if (rst) begin
      for (int i = 0; i < 64; i++) mem_ff[i] <= 16'hffff;
      {lock_ff, first_ff, busy_ff, stat_ff, rd_ff} <= {4'hf, 8'h00, 8'h00, 1'b0, 16'h0000};
      {program_error_flag, erase_error_flag, lock_status_flag} <= 3'h0;
    end else if (bus.re) begin
      rd_ff <= stat_ff ? {8'h00, sequencer_ready_flag, 1'b0, erase_error_flag, program_error_flag, 4'h0}
                       : mem_ff[bus.addr[6:1]];
    end else if (bus.we && first_ff != 8'h00) begin
      first_ff <= 8'h00;
      {pe_pend_ff, ee_pend_ff} <= 2'h0;
      if (first_ff != 8'h40 && code == 8'hff) begin  // cancel
        stat_ff <= 1'b0;
      end else if (first_ff != 8'h40 && code != 8'hd0) begin
        {program_error_flag, erase_error_flag} <= 2'h3;
      end else begin
        busy_ff <= busy_len;
        stat_ff <= first_ff != 8'h71;
        case (first_ff)
          8'h40: begin
            if (open_ok) mem_ff[bus.addr[6:1]] <= bus.wdata;
            else pe_pend_ff <= 1'b1;
          end
          8'h20: begin
            if (open_ok) begin
              for (int i = 0; i < 16; i++) mem_ff[{blk, i[3:0]}] <= 16'hffff;
              lock_ff[blk] <= 1'b1;
            end else ee_pend_ff <= 1'b1;
          end
          8'h77: lock_ff[blk] <= 1'b0;
          default: lock_status_flag <= lock_ff[blk];
        endcase
      end
    end else if (bus.we) begin
      case (code)  // other codes change nothing
        8'hff: stat_ff <= 1'b0;
        8'h70: stat_ff <= 1'b1;
        8'h50: {program_error_flag, erase_error_flag} <= 2'h0;
        8'h71: first_ff <= code;
        8'h40, 8'h20, 8'h77: if (!(program_error_flag | erase_error_flag)) first_ff <= code;
        default: ;
      endcase
    end
  end
endmodule : fcs_flash_model

/* File: tb/tb_top.sv */
// tb_top: drives the sequencer user port against the flash model, compares with a reference model
// assumes the design, the package and the flash model are compiled first
`timescale 1ns/10ps
module tb_top;
  logic clk_sys, rst, cmd_valid, cmd_ready, resp_valid, sequencer_ready_flag, program_error_flag;
  logic erase_error_flag, lock_status_flag, flash_executed_rewrite_mode, main_clock_stop_bit;
  logic rewrite_en_req, wait_req, stop_req, cpu_rewrite_enable, dma_disable, stop_mode_bit;
  logic lock_disable_bit, pe, ee, sm, en;
  logic [7:0]  busy_len;
  logic [15:0] dev_rdata, m [64];
  logic [19:0] prot_lo, prot_hi;
  logic [3:0]  lk;
  logic [4:0]  o;
  int          miscompares, checks_done, b;
  fcs_pkg::fcs_cmd_t  cmd;
  fcs_pkg::fcs_resp_t resp;
  fcs_pkg::fcs_bus_t  bus;
  fcs_sequencer dut (.clk_sys, .rst, .cmd_valid, .cmd, .cmd_ready, .resp_valid, .resp, .bus, .dev_rdata,
    .sequencer_ready_flag, .program_error_flag, .erase_error_flag, .lock_status_flag,
    .flash_executed_rewrite_mode, .main_clock_stop_bit, .prot_lo, .prot_hi, .rewrite_en_req, .wait_req,
    .stop_req, .cpu_rewrite_enable, .dma_disable, .stop_mode_bit);
  fcs_flash_model flash (.clk_sys, .rst, .bus, .lock_disable_bit, .busy_len, .dev_rdata,
    .sequencer_ready_flag, .program_error_flag, .erase_error_flag, .lock_status_flag);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic run(input logic [2:0] op, input int b, input logic [4:0] o, input logic [15:0] d);
    logic [19:0] a;
    logic [15:0] ed, mk;
    logic        rf;
    int          n;
    a = {13'h0, b[1:0], o[4:1], 1'b0};
    rf = (op != 3'h0 && !en) || (op > 3'h3 && main_clock_stop_bit) || (op == 3'h2 && flash_executed_rewrite_mode)
      || (op inside {3'h4, 3'h5} && flash_executed_rewrite_mode && a >= prot_lo && a <= prot_hi);
    mk = 16'h0;
    if (!rf) begin
      case (op)
        3'h0: mk = 16'hffff;
        3'h1: sm = 1'b0;
        3'h2: {sm, mk} = {1'b1, 16'hffff};
        3'h3: {pe, ee} = 2'h0;
        3'h7: {sm, mk} = {1'b0, 16'h0001};
        default: begin
          if (!(pe | ee)) begin
            if (op == 3'h6) lk[b] = 1'b0;
            else if (!(lock_disable_bit | lk[b])) {pe, ee} = {op == 3'h4, op == 3'h5};
            else if (op == 3'h4) m[a[6:1]] = d;
            else begin
              for (int i = 0; i < 16; i++) m[{b[1:0], i[3:0]}] = 16'hffff;
              lk[b] = 1'b1;
            end
          end
          {sm, mk} = {1'b1, 16'h00b0};
        end
      endcase
    end
    ed = (op == 3'h7) ? {15'h0, lk[b]} : sm ? {8'h00, 2'h2, ee, pe, 4'h0} : m[a[6:1]];
    n = 0;
    while (cmd_ready !== 1'b1) begin
      if (n++ > 50) begin
        miscompares++;
        close_out();
      end
      @(negedge clk_sys);
    end
    cmd_valid = 1'b1;
    cmd = '{fcs_pkg::fcs_op_t'(op), a, d};
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1) begin
      if (n++ > 400) begin
        miscompares++;
        close_out();
      end
      @(negedge clk_sys);
    end
    check({13'h0, resp.refused, resp.prog_err, resp.erase_err}, {13'h0, rf, (op > 3'h3 && !rf) ? {pe, ee} : 2'h0});
    check(resp.data & mk, ed & mk);
  endtask : run
  initial begin
    {rst, cmd_valid, flash_executed_rewrite_mode, main_clock_stop_bit, wait_req, stop_req} = 6'h20;
    {lock_disable_bit, pe, ee, sm, en, rewrite_en_req} = 6'h03;
    {cmd, busy_len, prot_lo, prot_hi, lk} = {27'h0, 8'h04, 20'h00040, 20'h0005f, 4'hf};
    {miscompares, checks_done} = 0;
    for (int i = 0; i < 64; i++) m[i] = 16'hffff;
    void'($urandom(32'h45082d73));
    repeat (6) @(negedge clk_sys);
    check({11'h0, bus.we, bus.re, resp_valid, dma_disable, stop_mode_bit}, 16'h0);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      busy_len = 8'($urandom_range(20, 1));
      b = $urandom_range(1, 0);
      o = 5'($urandom);
      run(3'h4, b, o, 16'($urandom));
      run(3'h0, b, o, 16'h0);
      run(3'h1, b, o, 16'h0);
      run(3'h0, b, o, 16'h0);
    end
    run(3'h2, 0, 5'h0, 16'h0);
    run(3'h0, 0, 5'h0, 16'h0);
    run(3'h6, 2, 5'h1e, 16'h0);
    run(3'h7, 2, 5'h1e, 16'h0);
    run(3'h4, 2, 5'h04, 16'h1234);
    run(3'h4, 2, 5'h04, 16'h1200);
    run(3'h3, 0, 5'h0, 16'h0);
    run(3'h5, 2, 5'h1e, 16'h0);
    run(3'h3, 0, 5'h0, 16'h0);
    lock_disable_bit = 1'b1;
    run(3'h7, 2, 5'h1e, 16'h0);
    run(3'h4, 2, 5'h04, 16'h5a5a);
    run(3'h5, 2, 5'h1e, 16'h0);
    lock_disable_bit = 1'b0;
    run(3'h7, 2, 5'h1e, 16'h0);
    run(3'h1, 2, 5'h0, 16'h0);
    run(3'h0, 2, 5'h04, 16'h0);
    flash_executed_rewrite_mode = 1'b1;
    run(3'h2, 0, 5'h0, 16'h0);
    run(3'h4, 2, 5'h04, 16'h0);
    run(3'h4, 0, 5'h04, 16'h7777);
    {flash_executed_rewrite_mode, main_clock_stop_bit} = 2'h1;
    run(3'h7, 0, 5'h1e, 16'h0);
    run(3'h1, 0, 5'h0, 16'h0);
    {main_clock_stop_bit, rewrite_en_req} = 2'h0;
    repeat (2) @(negedge clk_sys);
    en = 1'b0;
    run(3'h3, 0, 5'h0, 16'h0);
    {rewrite_en_req, en} = 2'h3;
    repeat (3) @(negedge clk_sys);
    stop_req = 1'b1;
    @(negedge clk_sys);
    check({13'h0, cpu_rewrite_enable, dma_disable, stop_mode_bit}, 16'h0);
    @(negedge clk_sys);
    check({13'h0, cpu_rewrite_enable, dma_disable, stop_mode_bit}, 16'h2);
    @(negedge clk_sys);
    check({12'h0, cmd_ready, cpu_rewrite_enable, dma_disable, stop_mode_bit}, 16'h3);
    stop_req = 1'b0;
    repeat (3) @(negedge clk_sys);
    wait_req = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({15'h0, cpu_rewrite_enable}, 16'h0);
    wait_req = 1'b0;
    repeat (3) @(negedge clk_sys);
    run(3'h0, 0, 5'h04, 16'h0);
    close_out();
  end
endmodule : tb_top
